// ### rtl/ep_pwm_top.sv
// Enhanced PWM with half-bridge, dead band and auto-shutdown behind APB
//
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/100ps

module ep_pwm_top
    import ep_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        int_pin_n,
    input  wire logic        comp_out,
    input  wire logic        sec_timer_tick,
    input  wire logic        sleep,
    output ep_pin_t          output_pin_a,
    output ep_pin_t          output_pin_b
);

    // ************************************************************
    // Registers
    // ************************************************************
    ep_ctl_t     ctl_reg;
    logic [7:0]  duty_hi_reg;
    ep_sd_t      sd_reg;
    ep_db_t      db_reg;
    logic [7:0]  period_reg;
    logic        run_reg;
    logic [1:0]  presc_reg;
    logic        flag_reg;
    logic [1:0]  dir_reg;
    logic        comparator_sync_enable_reg;
    logic [3:0]  pre_reg;
    logic [1:0]  q_reg;
    logic [7:0]  tmr_reg;
    logic [9:0]  duty_lat_reg;
    logic        run_ok_reg;
    logic [1:0]  int_s1_reg;
    logic [1:0]  cmp_s1_reg;
    logic        int_s2_reg;
    logic        cmp_s2_reg;
    logic        cmp_lat_reg;
    logic [31:0] prdata_reg;
    logic        pready_reg;
    logic        pslverr_reg;
    logic [8:0]  db_cnt_reg [2];
    ep_pin_t     pin_reg [2];
    logic        wr_en;
    logic        rd_setup;
    logic [31:0] rd_data;
    logic        rd_err;
    logic        owned;
    logic        half;
    logic        tick;
    logic        period_end;
    logic [3:0]  pre_max;
    logic        pwm;
    logic        comp_eff;
    logic        cond;
    logic        wr_sd;
    logic [8:0]  db_target;
    logic [1:0]  raw;
    logic [1:0]  act;
    logic [1:0]  pol_lo;
    logic [1:0]  sd_state [2];
    logic [1:0]  pin_used;
    // ************************************************************
    // APB slave
    // ************************************************************
    // Read data is staged in the setup phase so no wait state is needed
    assign wr_en    = psel && penable && pwrite;
    assign rd_setup = psel && !penable;
    assign wr_sd    = wr_en && (paddr == OFS_SD);
    always_comb begin
        rd_data = '0;
        rd_err  = 1'b0;
        case (paddr)
            OFS_CTL:  rd_data[7:0] = ctl_reg;
            OFS_DUTY: rd_data[7:0] = duty_hi_reg;
            OFS_SD:   rd_data[7:0] = sd_reg;
            OFS_DB:   rd_data[7:0] = db_reg;
            OFS_PER:  rd_data[7:0] = period_reg;
            OFS_TBC:  rd_data[2:0] = {run_reg, presc_reg};
            OFS_FLG:  rd_data[0]   = flag_reg;
            OFS_DIR:  rd_data[1:0] = dir_reg;
            OFS_CMP:  rd_data[0]   = comparator_sync_enable_reg;
            OFS_TMR:  rd_data[7:0] = tmr_reg;
            default:  rd_err       = 1'b1;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg  <= '0;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg <= 1'b1;
            if (rd_setup) begin
                prdata_reg  <= pwrite ? '0 : rd_data;
                pslverr_reg <= rd_err;
            end
        end
    end

    assign prdata  = prdata_reg;
    assign pready  = pready_reg;
    assign pslverr = pslverr_reg;
    // Plain configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_reg     <= RST_BYTE;
            duty_hi_reg <= RST_BYTE;
            db_reg      <= RST_BYTE;
            period_reg  <= RST_BYTE;
            run_reg     <= 1'b0;
            presc_reg   <= PS_1;
            dir_reg     <= RST_DIR;
            comparator_sync_enable_reg  <= 1'b0;
        end else if (wr_en) begin
            case (paddr)
                OFS_CTL:  ctl_reg     <= pwdata[7:0];
                OFS_DUTY: duty_hi_reg <= pwdata[7:0];
                OFS_DB:   db_reg      <= pwdata[7:0];
                OFS_PER:  period_reg  <= pwdata[7:0];
                OFS_TBC:  {run_reg, presc_reg} <= pwdata[2:0];
                OFS_DIR:  dir_reg     <= pwdata[1:0];
                OFS_CMP:  comparator_sync_enable_reg  <= pwdata[0];
                default:  ;
            endcase
        end
    end

    // ************************************************************
    // Time base
    // ************************************************************
    always_comb begin
        case (presc_reg)
            PS_1:    pre_max = PS1_MAX;
            PS_4:    pre_max = PS4_MAX;
            default: pre_max = PS16_MAX;
        endcase
    end
    // The two fine bits make the 10-bit base at prescaled-tick resolution
    assign tick       = run_reg && !sleep && (pre_reg == pre_max);
    assign period_end = tick && (q_reg == Q_LAST) && (tmr_reg == period_reg);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_reg <= '0;
            q_reg   <= '0;
            tmr_reg <= '0;
        end else if (run_reg && !sleep) begin
            pre_reg <= tick ? '0 : pre_reg + 4'h1;
            if (tick) begin
                q_reg <= q_reg + 2'h1;
                if (q_reg == Q_LAST) begin
                    tmr_reg <= period_end ? '0 : tmr_reg + 8'h1;
                end
            end
        end
    end
    // Duty is double buffered so a write mid-period cannot glitch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            duty_lat_reg <= '0;
        end else if (period_end) begin
            duty_lat_reg <= {duty_hi_reg, ctl_reg.duty_lo};
        end
    end
    // Match flag: a period end beats a clearing write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_reg <= 1'b0;
        end else if (period_end) begin
            flag_reg <= 1'b1;
        end else if (wr_en && (paddr == OFS_FLG)) begin
            flag_reg <= pwdata[0];
        end
    end

    assign pwm = ({tmr_reg, q_reg} < duty_lat_reg);
    // ************************************************************
    // Shutdown sources
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_s1_reg <= '1;
            int_s2_reg <= 1'b1;
            cmp_s1_reg <= '0;
            cmp_s2_reg <= 1'b0;
            cmp_lat_reg <= 1'b0;
        end else begin
            int_s1_reg <= {int_s1_reg[0], int_pin_n};
            cmp_s1_reg <= {cmp_s1_reg[0], comp_out};
            int_s2_reg <= int_s1_reg[1];
            cmp_s2_reg <= cmp_s1_reg[1];
            if (sec_timer_tick) begin
                cmp_lat_reg <= cmp_s2_reg;
            end
        end
    end

    assign comp_eff = comparator_sync_enable_reg ? cmp_lat_reg : cmp_s2_reg;
    // Level sensitive, so the condition holds as long as the source does; with sync on, the comparator holds until the next sec_timer_tick
    assign cond = (sd_reg.src[0] && comp_eff) || (sd_reg.src[2] && !int_s2_reg);
    // Status bit: a live condition wins over a write except during sleep
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sd_reg <= RST_BYTE;
        end else begin
            if (wr_sd) begin
                sd_reg.src  <= pwdata[6:4];
                sd_reg.st_a <= pwdata[3:2];
                sd_reg.st_b <= pwdata[1:0];
            end
            if (cond && !sleep) begin
                sd_reg.status <= 1'b1;
            end else if (wr_sd) begin
                sd_reg.status <= pwdata[7];
            end else if (db_reg.restart && !sleep) begin
                sd_reg.status <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Output path
    // ************************************************************
    assign owned = (ctl_reg.pol[3:2] == PWM_SEL);
    assign half  = (ctl_reg.mode == MODE_HALF);
    // Waveform waits for the next period end after enable or restart
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_ok_reg <= 1'b0;
        end else if (!owned || sd_reg.status) begin
            run_ok_reg <= 1'b0;
        end else if (period_end) begin
            run_ok_reg <= 1'b1;
        end
    end

    assign raw[0]    = run_ok_reg && pwm;
    assign raw[1]    = run_ok_reg && !pwm && half;
    assign db_target = half ? 9'(db_reg.count) * OSC_PER_TCY : '0;
    assign pol_lo    = {ctl_reg.pol[0], ctl_reg.pol[1]};
    assign sd_state[0] = sd_reg.st_a;
    assign sd_state[1] = sd_reg.st_b;
    // Pin B is left to its port function in single mode
    assign pin_used  = {half, 1'b1};
    for (genvar i = 0; i < 2; i++) begin : g_out
        // Counter restarts whenever the scheduled level goes inactive
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                db_cnt_reg[i] <= '0;
            end else if (!sleep) begin
                if (!raw[i]) begin
                    db_cnt_reg[i] <= '0;
                end else if (db_cnt_reg[i] < db_target) begin
                    db_cnt_reg[i] <= db_cnt_reg[i] + 9'h001;
                end
            end
        end

        // Short active phase never reaches the target, output stays off
        assign act[i] = raw[i] && (db_cnt_reg[i] >= db_target);
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                pin_reg[i] <= '0;
            end else if (!sleep) begin
                pin_reg[i].oe <= owned && pin_used[i] && !dir_reg[i]
                    && !(sd_reg.status && sd_state[i][1]);
                if (sd_reg.status) begin
                    pin_reg[i].out <= sd_state[i][0];
                end else begin
                    pin_reg[i].out <= act[i] ^ pol_lo[i];
                end
            end
        end
    end

    assign output_pin_a = pin_reg[0];
    assign output_pin_b = pin_reg[1];
    // ************************************************************
    // Assertions
    // ************************************************************
    a_sd_set_cond: assert property (
        @(posedge pclk) disable iff (!presetn)
        cond && !sleep |=> sd_reg.status ##1 (sd_reg.status || !cond))
        else $error("shutdown status not set by condition");

    a_sd_write_block: assert property (
        @(posedge pclk) disable iff (!presetn)
        cond && !sleep && wr_sd && !pwdata[7] |=> sd_reg.status)
        else $error("status write accepted during shutdown");

    a_fw_event: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_sd && pwdata[7] |=> sd_reg.status ##1 !run_ok_reg)
        else $error("firmware shutdown not taken");

    a_auto_restart: assert property (
        @(posedge pclk) disable iff (!presetn)
        sd_reg.status && db_reg.restart && !cond && !sleep && !wr_sd
        |=> !sd_reg.status)
        else $error("auto restart did not clear status");

    a_sd_hold: assert property (
        @(posedge pclk) disable iff (!presetn)
        sd_reg.status && !db_reg.restart && !wr_sd |=> sd_reg.status)
        else $error("status cleared without firmware");

    a_sd_pin_state: assert property (
        @(posedge pclk) disable iff (!presetn)
        sd_reg.status && !sleep |=> output_pin_a.out == $past(sd_reg.st_a[0])
        && (!output_pin_a.oe || !$past(sd_reg.st_a[1])))
        else $error("pin A not in shutdown state");

    a_resume_edge: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(run_ok_reg) |-> $past(period_end) && !$past(sd_reg.status))
        else $error("waveform started off a period boundary");

    a_no_overlap: assert property (
        @(posedge pclk) disable iff (!presetn)
        half && db_reg.count != '0 |-> !(act[0] && act[1]))
        else $error("both half-bridge outputs active");

    a_fall_undelayed: assert property (
        @(posedge pclk) disable iff (!presetn)
        $fell(raw[0]) && !sleep && !sd_reg.status |=> output_pin_a.out == $past(ctl_reg.pol[1]))
        else $error("active-to-inactive edge delayed");
    a_dead_band: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(act[1]) && $stable(db_target) && !$past(sleep) |-> db_cnt_reg[1] == db_target)
        else $error("dead band count wrong");

    a_polarity: assert property (
        @(posedge pclk) disable iff (!presetn)
        !sd_reg.status && !sleep |=> output_pin_a.out
        == ($past(act[0]) ^ $past(ctl_reg.pol[1])))
        else $error("pin A polarity wrong");

    a_release: assert property (
        @(posedge pclk) disable iff (!presetn)
        ctl_reg == RST_BYTE && !sleep |=> !output_pin_a.oe && !output_pin_b.oe)
        else $error("pins driven with control cleared");

    a_dir_input: assert property (
        @(posedge pclk) disable iff (!presetn)
        dir_reg[0] && !sleep |=> !output_pin_a.oe)
        else $error("pin A driven while input");

    a_single_b: assert property (
        @(posedge pclk) disable iff (!presetn)
        !half && !sleep |=> !output_pin_b.oe)
        else $error("pin B driven in single mode");

    a_sleep_freeze: assert property (
        @(posedge pclk) disable iff (!presetn)
        sleep |=> $stable(tmr_reg) && $stable(q_reg) && $stable(output_pin_a))
        else $error("state changed during sleep");

endmodule

// ### rtl/ep_pkg.sv
// Package with register map, field layouts and constants of the enhanced PWM
package ep_pkg;

    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam logic [7:0] OFS_CTL  = 8'h00;
    localparam logic [7:0] OFS_DUTY = 8'h04;
    localparam logic [7:0] OFS_SD   = 8'h08;
    localparam logic [7:0] OFS_DB   = 8'h0c;
    localparam logic [7:0] OFS_PER  = 8'h10;
    localparam logic [7:0] OFS_TBC  = 8'h14;
    localparam logic [7:0] OFS_FLG  = 8'h18;
    localparam logic [7:0] OFS_DIR  = 8'h1c;
    localparam logic [7:0] OFS_CMP  = 8'h20;
    localparam logic [7:0] OFS_TMR  = 8'h24;

    // ************************************************************
    // Reset values and codes
    // ************************************************************
    localparam logic [7:0] RST_BYTE  = 8'h00;
    localparam logic [1:0] RST_DIR   = 2'h3;
    localparam logic [1:0] MODE_HALF = 2'h2;
    localparam logic [1:0] PWM_SEL   = 2'h3;
    localparam logic [1:0] PS_1      = 2'h0;
    localparam logic [1:0] PS_4      = 2'h1;
    localparam logic [3:0] PS1_MAX   = 4'h0;
    localparam logic [3:0] PS4_MAX   = 4'h3;
    localparam logic [3:0] PS16_MAX  = 4'hf;
    localparam logic [1:0] Q_LAST    = 2'h3;
    localparam logic [8:0] OSC_PER_TCY = 9'h004;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic [1:0] mode;
        logic [1:0] duty_lo;
        logic [3:0] pol;
    } ep_ctl_t;

    typedef struct packed {
        logic       status;
        logic [2:0] src;
        logic [1:0] st_a;
        logic [1:0] st_b;
    } ep_sd_t;

    typedef struct packed {
        logic       restart;
        logic [6:0] count;
    } ep_db_t;

    typedef struct packed {
        logic out;
        logic oe;
    } ep_pin_t;

endpackage

// ### tb/ep_bridge_model.sv
// Half-bridge power switch pair seen by the two modulator pins
`timescale 1ns/100ps

module ep_bridge_model
    import ep_pkg::*;
(
    input  wire logic    pclk,
    input  wire ep_pin_t pin_a,
    input  wire ep_pin_t pin_b,
    output logic         level_a,
    output logic         level_b,
    output int           shoot_cnt
);
    // ************************************************************
    // Gate levels and shoot-through watch
    // ************************************************************
    // Pull-downs keep a released gate off, as the switches need
    assign level_a = pin_a.oe ? pin_a.out : 1'b0;
    assign level_b = pin_b.oe ? pin_b.out : 1'b0;
    int shoot_q = 0;
    assign shoot_cnt = shoot_q;
    // Both switches on at once shorts the bridge supply
    always @(posedge pclk) begin
        if (level_a === 1'b1 && level_b === 1'b1) begin
            shoot_q <= shoot_q + 1;
        end
    end
endmodule

// ### tb/tb.sv
// Self-checking bench of the enhanced PWM block over APB
`timescale 1ns/100ps

module tb
    import ep_pkg::*;
;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        int_pin_n = 1'b1;
    logic        comp_out = 1'b0;
    logic        sec_timer_tick = 1'b0;
    logic        sleep = 1'b0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    ep_pin_t     output_pin_a;
    ep_pin_t     output_pin_b;
    logic        level_a;
    logic        level_b;
    int          shoot_cnt;
    int          fail_count = 0;
    int          n_tests = 0;
    int          cyc = 0;
    logic [31:0] rd;
    logic        er;
    logic [31:0] seed = 32'hf712;

    always #50 pclk = ~pclk;

    ep_pwm_top u_ep_pwm_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .int_pin_n(int_pin_n), .comp_out(comp_out),
        .sec_timer_tick(sec_timer_tick), .sleep(sleep), .output_pin_a(output_pin_a),
        .output_pin_b(output_pin_b));
    ep_bridge_model u_ep_bridge_model (.pclk(pclk), .pin_a(output_pin_a),
        .pin_b(output_pin_b), .level_a(level_a), .level_b(level_b), .shoot_cnt(shoot_cnt));

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Dead band eats the front of each active phase only
    function automatic int exp_act(input int ticks, input int ps, input int dbv);
        return ticks * ps - 4 * dbv;
    endfunction

    function automatic logic lv(input int s);
        return s ? level_b : level_a;
    endfunction

    task automatic final_report();
        $display("Counts: %0d checks, %0d mismatches", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    // Sampled on the falling edge, away from the pin register updates
    task automatic measure(input int s, input logic p, output int hi, output int lo);
        hi = 0;
        lo = 0;
        while ((lv(s) ^ p) !== 1'b0) @(negedge pclk);
        while ((lv(s) ^ p) !== 1'b1) @(negedge pclk);
        while ((lv(s) ^ p) === 1'b1) begin
            hi++;
            @(negedge pclk);
        end
        while ((lv(s) ^ p) === 1'b0) begin
            lo++;
            @(negedge pclk);
        end
    endtask

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 60000) begin
            fail_count++;
            final_report();
        end
    end

    // ************************************************************
    // Scenarios
    // ************************************************************
    initial begin
        logic [7:0] ofs [10];
        logic [7:0] per;
        logic [9:0] dut;
        logic [1:0] pl;
        logic       ex;
        logic [3:0] pv;
        int         ps, pd, dbv, hi, lo, s0, na, nb;
        ofs = '{OFS_CTL, OFS_DUTY, OFS_SD, OFS_DB, OFS_PER, OFS_TBC, OFS_FLG, OFS_DIR,
                OFS_CMP, OFS_TMR};
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check("reset_pins", {output_pin_a.oe, output_pin_b.oe}, 0);
        for (int k = 0; k < 10; k++) begin
            apb(1'b0, ofs[k], 0);
            check("reset_val", rd, (ofs[k] == OFS_DIR) ? 32'h3 : 32'h0);
        end
        apb(1'b0, 8'h28, 0);
        check("unmapped_err", er, 1'b1);
        check("unmapped", rd, 32'h0);
        $display("done: reset");
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(lfsr(seed));
            per = 8'h10 + 8'(seed[3:0]);
            ps = seed[4] ? 4 : 1;
            pd = 4 * (per + 1);
            dut = 10'(30 + seed[15:8] % (pd - 59));
            dbv = (i == 3) ? 127 : int'(seed[18:16]);
            pl = (i == 0) ? 2'b00 : seed[21:20];
            wr(OFS_DIR, 32'h3);
            wr(OFS_TBC, 0);
            wr(OFS_PER, per);
            wr(OFS_CTL, {24'h0, MODE_HALF, dut[1:0], PWM_SEL, pl});
            wr(OFS_DUTY, dut[9:2]);
            wr(OFS_DB, 32'(dbv));
            wr(OFS_FLG, 0);
            wr(OFS_TBC, {29'h0, 1'b1, seed[4] ? PS_4 : PS_1});
            do apb(1'b0, OFS_FLG, 0); while (rd[0] !== 1'b1);
            wr(OFS_DIR, 0);
            repeat (2 * pd * ps) @(posedge pclk);
            s0 = shoot_cnt;
            if (i < 3) begin
                measure(0, pl[1], hi, lo);
                check("a_active", hi, exp_act(dut, ps, dbv));
                check("a_period", hi + lo, pd * ps);
                measure(1, pl[0], hi, lo);
                check("b_active", hi, exp_act(pd - dut, ps, dbv));
                check("b_period", hi + lo, pd * ps);
            end else begin
                na = 0;
                nb = 0;
                repeat (2 * pd * ps) begin
                    @(negedge pclk);
                    na += ((level_a ^ pl[1]) === 1'b1);
                    nb += ((level_b ^ pl[0]) === 1'b1);
                end
                check("dead_band_a", na, 0);
                check("dead_band_b", nb, 0);
            end
            if (i == 0) check("shoot_through", shoot_cnt - s0, 0);
        end
        $display("done: half bridge");
        wr(OFS_CTL, {24'h0, 2'b00, dut[1:0], PWM_SEL, 2'b00});
        repeat (2 * pd * ps) @(posedge pclk);
        measure(0, 1'b0, hi, lo);
        check("single_a", hi, dut * ps);
        check("single_b_oe", output_pin_b.oe, 1'b0);
        @(posedge pclk);
        sleep <= 1'b1;
        repeat (3) @(posedge pclk);
        apb(1'b0, OFS_TMR, 0);
        s0 = rd;
        pv = {output_pin_a, output_pin_b};
        repeat (40) @(negedge pclk);
        check("sleep_pins", {output_pin_a, output_pin_b}, pv);
        apb(1'b0, OFS_TMR, 0);
        check("sleep_timer", rd, s0);
        sleep <= 1'b0;
        $display("done: single and sleep");
        wr(OFS_CTL, {24'h0, MODE_HALF, dut[1:0], PWM_SEL, 2'b00});
        wr(OFS_DB, 32'h80);
        for (int c = 0; c < 16; c++) begin
            ex = c[3] ? c[0] : c[2];
            wr(OFS_SD, {24'h0, 1'b0, 3'(c), 4'b0110});
            if (c[3]) comp_out <= 1'b1;
            else int_pin_n <= 1'b0;
            repeat (30) @(posedge pclk);
            apb(1'b0, OFS_SD, 0);
            check("sd_status", rd[7], ex);
            if (ex) check("sd_pins", {output_pin_a, output_pin_b.oe}, 3'b110);
            comp_out <= 1'b0;
            int_pin_n <= 1'b1;
            repeat (8) @(posedge pclk);
            apb(1'b0, OFS_SD, 0);
            check("sd_autoclear", rd[7], 1'b0);
        end
        wr(OFS_DB, 0);
        wr(OFS_SD, 32'h41);
        int_pin_n <= 1'b0;
        repeat (8) @(posedge pclk);
        wr(OFS_SD, 32'h41);
        apb(1'b0, OFS_SD, 0);
        check("sd_write_blocked", rd, 32'hc1);
        int_pin_n <= 1'b1;
        repeat (8) @(posedge pclk);
        apb(1'b0, OFS_SD, 0);
        check("sd_held", rd, 32'hc1);
        check("sd_pins_drive", {output_pin_a, output_pin_b}, 4'b0111);
        wr(OFS_SD, 32'h41);
        measure(0, 1'b0, hi, lo);
        check("restart_a", hi, dut * ps);
        wr(OFS_SD, 32'h85);
        repeat (3) @(posedge pclk);
        apb(1'b0, OFS_SD, 0);
        check("sd_firmware", rd, 32'h85);
        check("sd_fw_pins", {output_pin_a, output_pin_b}, 4'b1111);
        wr(OFS_SD, 32'h16);
        wr(OFS_CMP, 32'h1);
        comp_out <= 1'b1;
        repeat (20) @(posedge pclk);
        apb(1'b0, OFS_SD, 0);
        check("sync_wait", rd[7], 1'b0);
        sec_timer_tick <= 1'b1;
        @(posedge pclk);
        sec_timer_tick <= 1'b0;
        repeat (8) @(posedge pclk);
        apb(1'b0, OFS_SD, 0);
        check("sync_shutdown", rd[7], 1'b1);
        comp_out <= 1'b0;
        $display("done: shutdown");
        wr(OFS_CTL, 0);
        repeat (4) @(posedge pclk);
        check("release_pins", {output_pin_a.oe, output_pin_b.oe}, 0);
        $display("done: release");
        final_report();
    end
endmodule
